// ---- verilog/four_bit_bidir_port.sv ----
// four-pin general-purpose port with apb register access
// Operation
// - four pins; data and direction registers hold one bit per pin
// - direction bit one puts that pin's driver in high impedance
// - direction bit zero drives the pin from the output latch
// - pin 3 is input only; its direction bit reads one always
// - data read returns pin levels; data write updates the latch only
// - data writes load the latch straight from pwdata; no sampled levels merged
// - pin 3 reads zero while the reset-pin function is enabled
// - direction bits still control drivers of analog-selected pins
// - analog-selected pins read zero on digital reads
// - bits 7 to 4 of data and direction read zero, ignore writes
// - direction bits 2 to 0 are read/write and reset to one
// - on the small variant bidir pins and their bits read zero
// - analog select bits reset to one; set disables digital input
`timescale 1ns/1ps
`default_nettype none
module four_bit_bidir_port
  import port_pkg::*;
#(
  parameter logic FULL_PART = port_pkg::FULL_PART_DEFAULT
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [port_pkg::NUM_PINS-1:0]  pin_in,
  output logic      [port_pkg::NUM_BIDIR-1:0] pin_out,
  output logic      [port_pkg::NUM_BIDIR-1:0] pin_oe
);
  import port_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [NUM_BIDIR-1:0] out_latch;
  logic [NUM_BIDIR-1:0] dir_bits;
  logic [NUM_BIDIR-1:0] analog_sel;
  logic                 reset_pin_enable;
  logic [NUM_BIDIR-1:0] next_out_latch;
  logic [NUM_BIDIR-1:0] next_dir_bits;
  logic [NUM_BIDIR-1:0] next_analog_sel;
  logic                 next_reset_pin_enable;
  logic [31:0]          next_prdata;
  logic                 next_pslverr;
  logic [NUM_PINS-1:0]  pin_sync_lvl;
  logic [NUM_PINS-1:0]  pin_read;
  logic                 wr_take;
  logic                 rd_take;
  logic                 hit;

  initial begin
    if (NUM_PINS != NUM_BIDIR + 1) $error("port needs one input-only pin");
  end

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync_lvl)
  );

  // ------------------------------------------------------------
  // pin drivers and read-back
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_BIDIR; g++) begin : g_pin
      // driver follows direction regardless of analog select
      assign pin_oe[g]  = FULL_PART & ~dir_bits[g];
      assign pin_out[g] = FULL_PART & out_latch[g];
      // analog input forces digital read low
      assign pin_read[g] = FULL_PART & ~analog_sel[g] & pin_sync_lvl[g];
    end
  endgenerate

  assign pin_read[INPUT_ONLY_BIT] = ~reset_pin_enable & pin_sync_lvl[INPUT_ONLY_BIT];

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  assign pready  = 1'b1;
  assign hit     = (paddr == ADDR_PIN_DATA) || (paddr == ADDR_DIRECTION) ||
                   (paddr == ADDR_ANALOG_SEL) || (paddr == ADDR_CONFIG);
  assign wr_take = psel & penable & pwrite & pstrb[0];
  assign rd_take = psel & ~penable & ~pwrite;

  always_comb begin
    next_out_latch        = out_latch;
    next_dir_bits         = dir_bits;
    next_analog_sel       = analog_sel;
    next_reset_pin_enable = reset_pin_enable;
    next_prdata           = prdata;
    next_pslverr          = 1'b0;
    if (wr_take) begin
      case (paddr)
        ADDR_PIN_DATA: begin
          // whole-byte write: every latch bit is modified, so the merge keeps none
          // of the sampled levels; bit 3 has no latch and is dropped
          next_out_latch = pwdata[NUM_BIDIR-1:0];
        end
        ADDR_DIRECTION:  next_dir_bits   = pwdata[NUM_BIDIR-1:0];
        ADDR_ANALOG_SEL: next_analog_sel = pwdata[NUM_BIDIR-1:0];
        ADDR_CONFIG:     next_reset_pin_enable = pwdata[CFG_RESET_PIN_BIT];
        default:         next_out_latch  = out_latch;
      endcase
    end
    if (rd_take) begin
      case (paddr)
        ADDR_PIN_DATA:   next_prdata = {28'h0000000, pin_read};
        ADDR_DIRECTION:  next_prdata = {28'h0000000, 1'b1,
                                        dir_bits & {NUM_BIDIR{FULL_PART}}};
        ADDR_ANALOG_SEL: next_prdata = {29'h00000000,
                                        analog_sel & {NUM_BIDIR{FULL_PART}}};
        ADDR_CONFIG:     next_prdata = {30'h00000000, FULL_PART, reset_pin_enable};
        default:         next_prdata = 32'h00000000;
      endcase
    end
    if (psel & ~penable) begin
      next_pslverr = ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch        <= LATCH_RESET;
      dir_bits         <= DIR_RESET;
      analog_sel       <= ANALOG_RESET;
      reset_pin_enable <= RESET_PIN_RESET;
      prdata           <= 32'h00000000;
      pslverr          <= 1'b0;
    end else begin
      out_latch        <= next_out_latch;
      dir_bits         <= next_dir_bits;
      analog_sel       <= next_analog_sel;
      reset_pin_enable <= next_reset_pin_enable;
      prdata           <= next_prdata;
      pslverr          <= next_pslverr;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dir_drives_oe: assert property (pin_oe == (~dir_bits & {NUM_BIDIR{FULL_PART}}))
    else $error("output enable does not follow direction");
  a_latch_on_pin: assert property (pin_oe[0] |-> pin_out[0] == out_latch[0])
    else $error("pin not driven from latch");
  a_dir3_reads_one: assert property (rd_take && paddr == ADDR_DIRECTION |=> prdata[3])
    else $error("input-only direction bit read zero");
  a_write_latch: assert property (wr_take && paddr == ADDR_PIN_DATA |=>
                                  out_latch == $past(pwdata[NUM_BIDIR-1:0]))
    else $error("latch not loaded by data write");
  a_reset_pin_zero: assert property (
    rd_take && paddr == ADDR_PIN_DATA && reset_pin_enable |=> !prdata[3])
    else $error("input-only pin read nonzero in reset mode");
  a_analog_zero: assert property (
    rd_take && paddr == ADDR_PIN_DATA && analog_sel[1] |=> !prdata[1])
    else $error("analog pin read nonzero");
  a_upper_zero: assert property (rd_take && paddr != ADDR_CONFIG |=> prdata[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");
  a_dir_hold: assert property (!(wr_take && paddr == ADDR_DIRECTION) |=> $stable(dir_bits))
    else $error("direction changed without write");
  a_analog_oe: assert property (analog_sel[0] && !dir_bits[0] |-> pin_oe[0] == FULL_PART)
    else $error("analog select blocked driver");

  c_write_data: cover property (wr_take && paddr == ADDR_PIN_DATA);
  c_output_on:  cover property (pin_oe[2]);
  c_read_pins:  cover property (rd_take && paddr == ADDR_PIN_DATA ##1 prdata[0]);
  c_analog_drive: cover property (analog_sel[0] && pin_oe[0]);
  c_reset_pin:    cover property (rd_take && paddr == ADDR_PIN_DATA && reset_pin_enable);

  // ------------------------------------------------------------
  // read-back checks
  // ------------------------------------------------------------
  a_data_read_val: assert property (
    rd_take && paddr == ADDR_PIN_DATA |=>
    prdata == {28'h0000000, $past(pin_read)})
    else $error("pin data read does not match pin levels");
  a_pin3_read: assert property (
    rd_take && paddr == ADDR_PIN_DATA && !reset_pin_enable |=>
    prdata[INPUT_ONLY_BIT] == $past(pin_sync_lvl[INPUT_ONLY_BIT]))
    else $error("input-only pin read wrong level");
  a_dir_read: assert property (
    rd_take && paddr == ADDR_DIRECTION |=>
    prdata[NUM_BIDIR-1:0] == ($past(dir_bits) & {NUM_BIDIR{FULL_PART}}))
    else $error("direction read wrong");
  a_analog_read: assert property (
    rd_take && paddr == ADDR_ANALOG_SEL |=>
    prdata[NUM_BIDIR-1:0] == ($past(analog_sel) & {NUM_BIDIR{FULL_PART}}))
    else $error("analog select read wrong");
  a_cfg_read: assert property (
    rd_take && paddr == ADDR_CONFIG |=>
    prdata[1:0] == {FULL_PART, $past(reset_pin_enable)})
    else $error("config read wrong");
  a_word_upper_zero: assert property (
    rd_take |=>
    prdata[31:8] == 24'h000000)
    else $error("upper read bits nonzero");
  a_unmapped_zero: assert property (
    rd_take && !hit |=>
    prdata == 32'h00000000)
    else $error("unmapped read nonzero");
  a_read_hold: assert property (
    !rd_take |=>
    $stable(prdata))
    else $error("read data changed without read");

  // ------------------------------------------------------------
  // bus response checks
  // ------------------------------------------------------------
  a_zero_wait: assert property (
    psel |->
    pready)
    else $error("slave inserted a wait state");
  a_unmapped_err: assert property (
    psel && !penable && !hit |=>
    pslverr)
    else $error("unmapped access without error");
  a_mapped_no_err: assert property (
    psel && !penable && hit |=>
    !pslverr)
    else $error("mapped access flagged error");
  a_err_one_cycle: assert property (
    pslverr |=>
    !pslverr)
    else $error("error response held too long");

  // ------------------------------------------------------------
  // storage checks
  // ------------------------------------------------------------
  a_latch_hold: assert property (
    !(wr_take && paddr == ADDR_PIN_DATA) |=>
    $stable(out_latch))
    else $error("latch changed without data write");
  a_analog_hold: assert property (
    !(wr_take && paddr == ADDR_ANALOG_SEL) |=>
    $stable(analog_sel))
    else $error("analog select changed without write");
  a_cfg_hold: assert property (
    !(wr_take && paddr == ADDR_CONFIG) |=>
    $stable(reset_pin_enable))
    else $error("config changed without write");
  a_dir_write: assert property (
    wr_take && paddr == ADDR_DIRECTION |=>
    dir_bits == $past(pwdata[NUM_BIDIR-1:0]))
    else $error("direction not loaded by write");
  a_analog_write: assert property (
    wr_take && paddr == ADDR_ANALOG_SEL |=>
    analog_sel == $past(pwdata[NUM_BIDIR-1:0]))
    else $error("analog select not loaded by write");
  a_cfg_write: assert property (
    wr_take && paddr == ADDR_CONFIG |=>
    reset_pin_enable == $past(pwdata[CFG_RESET_PIN_BIT]))
    else $error("config not loaded by write");
  a_strb_gate: assert property (
    psel && penable && pwrite && !pstrb[0] |=>
    $stable(out_latch) && $stable(dir_bits) && $stable(analog_sel) && $stable(reset_pin_enable))
    else $error("write without strobe changed state");
  a_unmapped_write: assert property (
    wr_take && !hit |=>
    $stable(out_latch) && $stable(dir_bits) && $stable(analog_sel) && $stable(reset_pin_enable))
    else $error("unmapped write changed state");

  // ------------------------------------------------------------
  // pin checks
  // ------------------------------------------------------------
  a_small_oe_off: assert property (
    !FULL_PART |->
    pin_oe == {NUM_BIDIR{1'b0}})
    else $error("small variant drives a pin");
  a_small_out_low: assert property (
    !FULL_PART |->
    pin_out == {NUM_BIDIR{1'b0}})
    else $error("small variant pin output nonzero");
  a_small_read_low: assert property (
    !FULL_PART |->
    pin_read[NUM_BIDIR-1:0] == {NUM_BIDIR{1'b0}})
    else $error("small variant absent pins read nonzero");
  a_analog_mask: assert property (
    (pin_read[NUM_BIDIR-1:0] & analog_sel) ==
    {NUM_BIDIR{1'b0}})
    else $error("analog pin passes digital level");
  a_reset_pin_mask: assert property (
    reset_pin_enable |->
    !pin_read[INPUT_ONLY_BIT])
    else $error("input-only pin passes level in reset mode");
  a_out_follows: assert property (
    1'b1 |->
    pin_out == (out_latch & {NUM_BIDIR{FULL_PART}}))
    else $error("pin output does not follow latch");
endmodule
`default_nettype wire

// ---- verilog/port_pkg.sv ----
// shared constants for the four-pin general-purpose port
package port_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_PIN_DATA   = 12'h000;
  localparam logic [11:0] ADDR_DIRECTION  = 12'h004;
  localparam logic [11:0] ADDR_ANALOG_SEL = 12'h008;
  localparam logic [11:0] ADDR_CONFIG     = 12'h00C;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int          NUM_PINS          = 4;
  localparam int          NUM_BIDIR         = 3;
  localparam int          INPUT_ONLY_BIT    = 3;
  localparam int          CFG_RESET_PIN_BIT = 0;
  localparam int          CFG_FULL_BIT      = 1;
  localparam logic [2:0]  DIR_RESET         = 3'h7;
  localparam logic [2:0]  ANALOG_RESET      = 3'h7;
  localparam logic [2:0]  LATCH_RESET       = 3'h0;
  localparam logic        RESET_PIN_RESET   = 1'h0;
  localparam logic        FULL_PART_DEFAULT = 1'h1;

  // ------------------------------------------------------------
  // bus access states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_e;

endpackage

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for the pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// ---- test/pin_partner.sv ----
// behavioural model of the circuitry outside the four port pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [3:0] ext_level,
  output logic      [3:0] pin_in
);
  // a driven pin shows the latch, a released one the outside level
  assign pin_in = {ext_level[3], (pin_oe & pin_out) | (~pin_oe & ext_level[2:0])};
endmodule
`default_nettype wire

// ---- test/four_bit_bidir_port_tb.sv ----
// testbench for the four-pin port with a behavioural register model
`timescale 1ns/1ps
`default_nettype none
module four_bit_bidir_port_tb;
  import port_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, prdata_s, r, rs, v;
  logic [3:0]  pstrb = 4'hF, ext = 4'h0, pin_in;
  logic        pready, pslverr, pready_s, pslverr_s, e, rpe;
  logic [2:0]  pin_out, pin_oe, lat, dir, ana;
  int          fail_count = 0, checks = 0, seed = 2661, cyc = 0;
  four_bit_bidir_port i_four_bit_bidir_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  four_bit_bidir_port #(.FULL_PART(1'b0)) i_four_bit_bidir_port_small (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_s), .pready(pready_s),
    .pslverr(pslverr_s), .pin_in(ext), .pin_out(), .pin_oe());
  pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));
  // ------------------------------------------------------------
  // clock, timeout, reporting
  // ------------------------------------------------------------
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // ------------------------------------------------------------
  // apb master and read model
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; rs = prdata_s; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function automatic logic [31:0] exp_data();
    logic [31:0] x;
    x = 32'h0;
    for (int i = 0; i < 3; i++) x[i] = ana[i] ? 1'b0 : (dir[i] ? ext[i] : lat[i]);
    x[3] = rpe ? 1'b0 : ext[3];
    return x;
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    chk("oe_in_reset", {pin_oe}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, ADDR_DIRECTION, 32'h0);
    chk("dir_reset", r, 32'h0000000F);
    chk("dir_small", rs, 32'h00000008);
    chk("out_reset", {pin_out}, 32'h0);
    apb(1'b0, ADDR_ANALOG_SEL, 32'h0);
    chk("analog_reset", r, 32'h00000007);
    chk("analog_small", rs, 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config_reset", r, 32'h00000002);
    chk("config_small", rs, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_data", r, 32'h0);
    chk("unmapped_err", {e}, 32'h1);
    $display("reset test done");
    for (int k = 0; k < 40; k++) begin
      v = $random(seed);
      ext <= v[3:0];
      v = $random(seed); apb(1'b1, ADDR_CONFIG, v); rpe = v[0];
      // clearing a select bit is what makes the pin readable
      v = $random(seed); apb(1'b1, ADDR_ANALOG_SEL, v); ana = v[2:0];
      v = $random(seed);
      // odd passes keep analog pins released; even passes let them drive
      if (k[0]) v[2:0] = v[2:0] | ana;
      apb(1'b1, ADDR_DIRECTION, v); dir = v[2:0];
      v = $random(seed); apb(1'b1, ADDR_PIN_DATA, v); lat = v[2:0];
      repeat (3) @(posedge pclk);
      #1;
      chk("pin_oe", {pin_oe}, {~dir});
      chk("pin_out", {pin_out}, {lat});
      apb(1'b0, ADDR_PIN_DATA, 32'h0);
      chk("pin_data", r, exp_data());
      chk("pin_data_small", rs, {ext[3] & ~rpe, 3'h0});
      apb(1'b0, ADDR_DIRECTION, 32'h0);
      chk("direction", r, {1'b1, dir});
    end
    $display("random test done");
    pstrb <= 4'hE;
    apb(1'b1, ADDR_DIRECTION, {29'h0, ~dir});
    pstrb <= 4'hF;
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk("unmapped_wr_err", {e}, 32'h1);
    apb(1'b0, ADDR_DIRECTION, 32'h0);
    chk("strobe_ignored", r, {1'b1, dir});
    apb(1'b0, ADDR_ANALOG_SEL, 32'h0);
    chk("unmapped_wr_ignored", r, {29'h0, ana});
    $display("refused write test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("oe_rereset", {pin_oe}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, ADDR_DIRECTION, 32'h0);
    chk("dir_rereset", r, 32'h0000000F);
    apb(1'b0, ADDR_ANALOG_SEL, 32'h0);
    chk("analog_rereset", r, 32'h00000007);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config_rereset", r, 32'h00000002);
    $display("second reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
